// [src/pcr_config_regs.v]
// Peripheral bank relocation, capture, release level and auxiliary config registers
//
// Behaviour
// - Relocation register resets to 20ffh
// - Role bit 1 slave, 0 master
// - Space bit selects memory or I/O decode
// - Base upper twelve bits; low byte zero
// - Memory space ignores base bits 19..16
// - Bank decodes as one 256-byte block
// - Reset rise captures sixteen bus pins
// - Capture is read-only, held until reset
// - Release code in high byte, low zero
// - Auxiliary register clears at reset
// - Per-port handshake input/output pin selects
// - Lower space width bit: 8 or 16
// - Middle, memory-mapped peripheral width select
// - I/O width bit selects 8-bit I/O
`timescale 1ns/1ps
`default_nettype none
`include "pcr_regs.vh"
module pcr_config_regs #(
  parameter [7:0] RELEASE_CODE = 8'h5a   // Arbitrary neutral value
) (
  input  wire        CLK_SYS,      // 40 MHz system clock
  input  wire        NRST,         // Synchronous reset, active low
  input  wire [19:0] ADDR,         // Access address
  input  wire        IS_MEM,       // 1 memory cycle, 0 I/O cycle
  input  wire        WR,           // Write strobe, one cycle
  input  wire        RD,           // Read strobe, one cycle
  input  wire [15:0] WDATA,        // Write data
  input  wire [15:0] PIN_LEVELS,   // Multiplexed address/data pin levels
  output reg  [15:0] RDATA,        // Read data, registered
  output wire        BANK_HIT,     // Access falls in the bank
  output wire        INTC_SLAVE,   // Interrupt controller slave mode
  output wire        BANK_IN_MEM,  // Bank mapped into memory space
  output wire [11:0] BANK_BASE,    // Bank base address bits 19..8
  output wire        P1_CTS_SEL,   // Port 1 input is clear-to-send
  output wire        P1_RTS_SEL,   // Port 1 output is request-to-send
  output wire        P0_CTS_SEL,   // Port 0 input is clear-to-send
  output wire        P0_RTS_SEL,   // Port 0 output is request-to-send
  output wire        LOWER_8BIT,   // Lower chip-select space 8-bit
  output wire        MIDDLE_8BIT,  // Middle chip-select space 8-bit
  output wire        PCS_MEM_8BIT, // Memory-mapped peripheral space 8-bit
  output wire        IO_8BIT       // All I/O space 8-bit
);
  reg  [15:0] relocation_reg;
  reg  [15:0] aux_reg;
  wire [15:0] captured;
  wire [7:0]  offs = ADDR[7:0];

  pcr_bank_decode u_dec (
    .base_field (relocation_reg[11:0]),
    .space_mem  (relocation_reg[`PCR_REL_SPACE_BIT]),
    .addr       (ADDR),
    .is_mem     (IS_MEM),
    .hit        (BANK_HIT)
  );

  pcr_capture u_cap (
    .clk      (CLK_SYS),
    .nrst     (NRST),
    .pins     (PIN_LEVELS),
    .captured (captured)
  );

  // Writes to read-only offsets are dropped; byte lanes are not split
  always @(posedge CLK_SYS) begin
    if (!NRST) begin
      relocation_reg <= `PCR_REL_RESET;
      aux_reg        <= `PCR_AUX_RESET;
    end else if (WR && BANK_HIT) begin
      if (offs == `PCR_OFF_REL) begin
        relocation_reg <= WDATA & `PCR_REL_WMASK;
      end
      if (offs == `PCR_OFF_AUX) begin
        aux_reg <= WDATA & `PCR_AUX_WMASK;
      end
    end
  end

  always @(posedge CLK_SYS) begin
    if (!NRST) begin
      RDATA <= 16'h0000;
    end else if (RD && BANK_HIT) begin
      case (offs)
        `PCR_OFF_REL: RDATA <= relocation_reg;
        `PCR_OFF_AUX: RDATA <= aux_reg;
        `PCR_OFF_CAP: RDATA <= captured;
        `PCR_OFF_RLC: RDATA <= {RELEASE_CODE, 8'h00};
        default:      RDATA <= 16'h0000;
      endcase
    end
  end

  assign INTC_SLAVE   = relocation_reg[`PCR_REL_ROLE_BIT];
  assign BANK_IN_MEM  = relocation_reg[`PCR_REL_SPACE_BIT];
  assign BANK_BASE    = relocation_reg[11:0];
  assign P1_CTS_SEL   = aux_reg[`PCR_AUX_PORT1_INPUT_HANDSHAKE_SELECT_BIT];
  assign P1_RTS_SEL   = aux_reg[`PCR_AUX_PORT1_OUTPUT_HANDSHAKE_SELECT_BIT];
  assign P0_CTS_SEL   = aux_reg[`PCR_AUX_PORT0_INPUT_HANDSHAKE_SELECT_BIT];
  assign P0_RTS_SEL   = aux_reg[`PCR_AUX_PORT0_OUTPUT_HANDSHAKE_SELECT_BIT];
  assign LOWER_8BIT   = aux_reg[`PCR_AUX_LOWER_SPACE_WIDTH_SELECT_BIT];
  assign MIDDLE_8BIT  = aux_reg[`PCR_AUX_MIDDLE_SPACE_WIDTH_SELECT_BIT];
  // Peripheral space only narrows when it is memory-mapped
  assign PCS_MEM_8BIT = aux_reg[`PCR_AUX_MIDDLE_SPACE_WIDTH_SELECT_BIT] & IS_MEM;
  assign IO_8BIT      = aux_reg[`PCR_AUX_IO_SPACE_WIDTH_SELECT_BIT];
endmodule // pcr_config_regs
`default_nettype wire

// [src/pcr_regs.vh]
// Offsets, field positions, reset values for the peripheral bank config registers
`ifndef PCR_REGS_VH
`define PCR_REGS_VH
`define PCR_OFF_AUX        8'hf2
`define PCR_OFF_RLC        8'hf4
`define PCR_OFF_CAP        8'hf6
`define PCR_OFF_REL        8'hfe
`define PCR_REL_RESET      16'h20ff
`define PCR_AUX_RESET      16'h0000
`define PCR_REL_WMASK      16'h5fff
`define PCR_AUX_WMASK      16'h007f
`define PCR_REL_ROLE_BIT   14
`define PCR_REL_SPACE_BIT  12
`define PCR_AUX_PORT1_INPUT_HANDSHAKE_SELECT_BIT  6
`define PCR_AUX_PORT1_OUTPUT_HANDSHAKE_SELECT_BIT   5
`define PCR_AUX_PORT0_INPUT_HANDSHAKE_SELECT_BIT  4
`define PCR_AUX_PORT0_OUTPUT_HANDSHAKE_SELECT_BIT   3
`define PCR_AUX_LOWER_SPACE_WIDTH_SELECT_BIT   2
`define PCR_AUX_MIDDLE_SPACE_WIDTH_SELECT_BIT   1
`define PCR_AUX_IO_SPACE_WIDTH_SELECT_BIT  0
`endif

// [src/pcr_bank_decode.v]
// Address match of the relocatable 256-byte peripheral register bank
`timescale 1ns/1ps
`default_nettype none
module pcr_bank_decode (
  input  wire [11:0] base_field,   // Upper base address bits 19..8
  input  wire        space_mem,    // 1 = bank in memory space
  input  wire [19:0] addr,         // Access address
  input  wire        is_mem,       // 1 = memory cycle, 0 = I/O cycle
  output wire        hit           // Access falls inside the bank
);
  // In memory space base bits 19..16 do not take part
  wire upper_ok = space_mem ? 1'b1 : (addr[19:16] == base_field[11:8]);
  wire mid_ok   = (addr[15:8] == base_field[7:0]);
  assign hit = (is_mem == space_mem) && upper_ok && mid_ok;
endmodule // pcr_bank_decode
`default_nettype wire

// [src/pcr_capture.v]
// Reset-time capture of the multiplexed address/data pins
`timescale 1ns/1ps
`default_nettype none
module pcr_capture (
  input  wire        clk,          // System clock
  input  wire        nrst,         // Synchronous reset, active low
  input  wire [15:0] pins,         // Bus pin levels
  output reg  [15:0] captured      // Value caught at reset release
);
  reg in_reset_reg;
  // Capture on the first edge after release, then hold until next reset
  always @(posedge clk) begin
    if (!nrst) begin
      in_reset_reg <= 1'b1;
    end else begin
      in_reset_reg <= 1'b0;
      if (in_reset_reg) begin
        captured <= pins;
      end
    end
  end
endmodule // pcr_capture
`default_nettype wire

// [tb/pcr_config_sva.sv]
// Port checks for the bank config registers
`timescale 1ns/1ps
`default_nettype none
module pcr_config_sva #(parameter [7:0] RELEASE_CODE = 8'h5a) (
  input wire logic CLK_SYS, NRST, RD, WR, IS_MEM, BANK_HIT, INTC_SLAVE, BANK_IN_MEM, PCS_MEM_8BIT, MIDDLE_8BIT,
  input wire logic IO_8BIT, input wire logic [19:0] ADDR, input wire logic [15:0] WDATA, RDATA, PIN_LEVELS,
  input wire logic [11:0] BANK_BASE);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!NRST);
  wire [13:0] rel = {INTC_SLAVE, BANK_IN_MEM, BANK_BASE};
  wire [13:0] rel_w = {WDATA[14], WDATA[12], WDATA[11:0]};
  wire wh = WR && BANK_HIT;
  wire rh = RD && BANK_HIT;
  // Pin levels seen at the first edge after reset release
  logic [15:0] cap_exp = 16'h0000;
  always @(posedge CLK_SYS) begin
    if ($rose(NRST)) cap_exp <= PIN_LEVELS;
  end
  sequence s_cap_rd; rh && ADDR[7:0] == 8'hf6; endsequence
  sequence s_cap_val; RDATA == cap_exp; endsequence
  property p_cap; s_cap_rd |=> s_cap_val; endproperty
  a_cap: assert property (p_cap) else $error("cap");
  property p_rel_rst; $rose(NRST) |-> rel == 14'h00ff; endproperty
  a_rel_rst: assert property (p_rel_rst) else $error("rel rst");
  property p_aux_rst; $rose(NRST) |-> {MIDDLE_8BIT, IO_8BIT} == 2'b00; endproperty
  a_aux_rst: assert property (p_aux_rst) else $error("aux rst");
  property p_rel_wr; wh && ADDR[7:0] == 8'hfe |=> rel == $past(rel_w); endproperty
  a_rel_wr: assert property (p_rel_wr) else $error("rel wr");
  property p_aux_wr; wh && ADDR[7:0] == 8'hf2 |=> {MIDDLE_8BIT, IO_8BIT} == $past(WDATA[1:0]); endproperty
  a_aux_wr: assert property (p_aux_wr) else $error("aux wr");
  property p_hit; BANK_HIT == (IS_MEM == BANK_IN_MEM
    && (IS_MEM ? ADDR[15:8] == BANK_BASE[7:0] : ADDR[19:8] == BANK_BASE)); endproperty
  a_hit: assert property (p_hit) else $error("hit");
  property p_pcs; PCS_MEM_8BIT == (MIDDLE_8BIT && IS_MEM); endproperty
  a_pcs: assert property (p_pcs) else $error("pcs");
  property p_prl; rh && ADDR[7:0] == 8'hf4 |=> RDATA == {RELEASE_CODE, 8'h00}; endproperty
  a_prl: assert property (p_prl) else $error("prl");
  property p_rsv; rh && ADDR[7:0] == 8'h00 |=> RDATA == 16'h0000; endproperty
  a_rsv: assert property (p_rsv) else $error("rsv");
endmodule // pcr_config_sva
`default_nettype wire

// [tb/tb_pcr_config_regs.sv]
// Register access bench for the bank config registers
`timescale 1ns/1ps
`default_nettype none
module tb_pcr_config_regs;
  logic clk = 0, nrst = 0, mem = 0, wr = 0, rd = 0;
  logic [19:0] addr = 0;
  logic [15:0] wdata = 0, pins = 16'h3c96;
  wire [15:0] rdata;
  wire [11:0] base;
  wire hit, slave, in_mem, p1c, p1r, p0c, p0r, lo8, mid8, pcs8, io8;
  int errors = 0, tests_run = 0;
  pcr_config_regs i_dut (.CLK_SYS(clk), .NRST(nrst), .ADDR(addr), .IS_MEM(mem), .WR(wr), .RD(rd), .WDATA(wdata),
    .PIN_LEVELS(pins), .RDATA(rdata), .BANK_HIT(hit), .INTC_SLAVE(slave), .BANK_IN_MEM(in_mem), .BANK_BASE(base),
    .P1_CTS_SEL(p1c), .P1_RTS_SEL(p1r), .P0_CTS_SEL(p0c), .P0_RTS_SEL(p0r), .LOWER_8BIT(lo8), .MIDDLE_8BIT(mid8),
    .PCS_MEM_8BIT(pcs8), .IO_8BIT(io8));
  initial forever #12.5 clk = ~clk;
  task chk(input logic [15:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %0t: %h not %h", $time, seen, exp);
    end
  endtask
  // Reads reuse d as the expected word
  task acc(input logic w, m, input logic [19:0] a, input logic [15:0] d);
    @(negedge clk);
    {wr, rd, mem, addr, wdata} = {w, !w, m, a, d};
    @(negedge clk);
    {wr, rd} = 2'b00;
    if (!w) chk(rdata, d);
  endtask
  // Reset held six cycles with given pin levels, pins dropped after release
  task reset_dut(input logic [15:0] p);
    {nrst, pins} = {1'b0, p};
    repeat (6) @(negedge clk);
    nrst = 1;
    repeat (2) @(negedge clk);
    pins = 16'h0000;
  endtask
  task conclude;
    if (errors == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    reset_dut(16'h3c96);
    acc(0, 0, 20'h0fffe, 16'h20ff);
    acc(0, 0, 20'h0fff2, 16'h0000);
    acc(0, 0, 20'h0fff6, 16'h3c96);
    acc(0, 0, 20'h0fff4, 16'h5a00);
    acc(1, 0, 20'h0fff2, 16'hffff);
    chk({9'h000, p1c, p1r, p0c, p0r, lo8, mid8, io8}, 16'h007f);
    chk({15'h0000, pcs8}, 16'h0000);
    acc(0, 0, 20'h0fff2, 16'h007f);
    acc(1, 0, 20'h0fff6, 16'h1234);
    acc(0, 0, 20'h0fff6, 16'h3c96);
    acc(0, 1, 20'h0fff4, 16'h3c96);
    acc(0, 0, 20'h0ff00, 16'h0000);
    acc(1, 0, 20'h0fffe, 16'hffff);
    chk({2'b00, slave, in_mem, base}, 16'h3fff);
    acc(0, 1, 20'h0fffe, 16'h5fff);
    acc(0, 1, 20'h5fff4, 16'h5a00);
    chk({14'h0000, hit, pcs8}, 16'h0003);
    acc(1, 1, 20'h3fffe, 16'h0012);
    chk({2'b00, slave, in_mem, base}, 16'h0012);
    acc(0, 0, 20'h012f4, 16'h5a00);
    reset_dut(16'ha5c3);
    acc(0, 0, 20'h0fff6, 16'ha5c3);
    acc(0, 0, 20'h0fffe, 16'h20ff);
    acc(0, 0, 20'h0fff2, 16'h0000);
    conclude;
  end
endmodule // tb_pcr_config_regs
bind pcr_config_regs pcr_config_sva #(.RELEASE_CODE(RELEASE_CODE)) i_sva (.*);
`default_nettype wire
